// ### svmon_params.svh
// Constants for the supply monitor control block
`ifndef SVMON_PARAMS_SVH
`define SVMON_PARAMS_SVH

// ==========================================================
// Register offsets (plain register port)
`define SVMON_ADDR_CTRL       4'h0
`define SVMON_ADDR_STAT       4'h1
`define SVMON_ADDR_STAT_RAW   4'h2

// ==========================================================
// Control and status field positions
`define SVMON_CTRL_EN_BIT     7
`define SVMON_CTRL_LVL_BIT    3
`define SVMON_CTRL_RST_BIT    2
`define SVMON_CTRL_FIE_BIT    1
`define SVMON_CTRL_RIE_BIT    0
`define SVMON_CTRL_RSVD_MASK  8'h70
`define SVMON_STAT_RSVD_MASK  8'hfc
`define SVMON_STAT_FALL_BIT   1
`define SVMON_STAT_RISE_BIT   0

// ==========================================================
// Reset values
`define SVMON_CTRL_RESET      8'h00
`define SVMON_FLAG_RESET      1'b0

// ==========================================================
// Timing
`define SVMON_RELEASE_CYCLES  131072
`define SVMON_CNT_W           18
// Software wait after enabling the detector, 50 us at 250 MHz
`define SVMON_EN_SETTLE_CYCLES 12500

`endif

// ### svmon_pkg.sv
// Types for the supply monitor control block
package svmon_pkg;
    typedef enum logic [1:0] {
        SVMON_RUN,
        SVMON_LOW,
        SVMON_WAIT
    } svmon_state_t;
endpackage

// ### svmon_ctrl.sv
// Supply monitor control: register, flags, interrupts, brownout reset
//
// Summary of operation
// R1: Bit 7 enables detector; 0 holds detector unit in standby.
// R2: Bits 6 to 4 read as 1; writes ignored.
// R3: Bit 3 selects reset level: 0 low 2.3 V, 1 high 3.6 V.
// R4: Software uses low level with interrupts, high level for reset only.
// R5: Bit 2 enables internal reset on low voltage.
// R6: Bit 1, reset 0, enables fall interrupt.
// R7: Bit 0, reset 0, enables rise interrupt.
// R8: Bits 7, 3, 2 cleared by power-on/watchdog reset, kept on brownout.
// R9: Software programs only the supported setting combinations.
// R10: Power-on reset always works; detector off makes other settings moot.
// R11: Flags clear by writing 0 after reading 1; device sets on events.
// R12: Rise flag set only if rise enable was 1 at the fall.
// R13: After recovery, count 131072 cycles before releasing brownout reset.
// R14: Software enables, waits 50 us, then sets reset enable; reverse off.
// R15: Interrupt request is flag AND its enable, per direction.
`timescale 1ns/1ps
`include "svmon_params.svh"

module svmon_ctrl (
    input  wire logic       clk_sys,       // System clock, 250 MHz
    input  wire logic       rst_n,         // Power-on or watchdog reset
    input  wire logic [3:0] reg_addr,      // Register address
    input  wire logic [7:0] reg_wdata,     // Write data
    input  wire logic       reg_wr,        // Write strobe
    input  wire logic       reg_rd,        // Read strobe
    output logic      [7:0] reg_rdata,     // Read data, cycle after read
    input  wire logic       cmp_fall,      // Comparator: below fall level
    input  wire logic       cmp_rise,      // Comparator: above rise level
    input  wire logic       cmp_reset_lo,  // Comparator: below 2.3 V
    input  wire logic       cmp_reset_hi,  // Comparator: below 3.6 V
    output logic            monitor_on,    // Analog unit active
    output logic            level_sel,     // Reset level to analog unit
    output logic            brownout_rst,  // Internal reset request
    output logic            fall_irq,      // Fall interrupt request
    output logic            rise_irq       // Rise interrupt request
);

    // ======================================================
    // Input synchronisers
    logic [3:0] cmp_s1_r;
    logic [3:0] cmp_s2_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmp_s1_r <= 4'h0;
            cmp_s2_r <= 4'h0;
        end else begin
            cmp_s1_r <= {cmp_fall, cmp_rise, cmp_reset_lo, cmp_reset_hi};
            cmp_s2_r <= cmp_s1_r;
        end
    end

    logic fall_s;
    logic rise_s;
    logic lo_s;
    logic hi_s;
    logic below_lvl;
    assign fall_s = cmp_s2_r[3];
    assign rise_s = cmp_s2_r[2];
    assign lo_s   = cmp_s2_r[1];
    assign hi_s   = cmp_s2_r[0];

    // ======================================================
    // Control register
    logic       en_r;
    logic       lvl_r;
    logic       rst_en_r;
    logic       fie_r;
    logic       rie_r;
    logic       bo_active;
    logic       wr_ctrl;
    logic       wr_stat;

    // Reset image of the control register
    localparam logic [7:0] CTRL_RST = `SVMON_CTRL_RESET;

    assign wr_ctrl = reg_wr && (reg_addr == `SVMON_ADDR_CTRL);
    assign wr_stat = reg_wr && (reg_addr == `SVMON_ADDR_STAT);

    // Fields kept across brownout; only rst_n clears them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            en_r     <= CTRL_RST[`SVMON_CTRL_EN_BIT];  // R8
            lvl_r    <= CTRL_RST[`SVMON_CTRL_LVL_BIT]; // R8
            rst_en_r <= CTRL_RST[`SVMON_CTRL_RST_BIT]; // R8
        end else if (wr_ctrl) begin
            en_r     <= reg_wdata[`SVMON_CTRL_EN_BIT];  // R1
            lvl_r    <= reg_wdata[`SVMON_CTRL_LVL_BIT]; // R3
            rst_en_r <= reg_wdata[`SVMON_CTRL_RST_BIT]; // R5
        end
    end

    // Interrupt enables also cleared by brownout
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fie_r <= CTRL_RST[`SVMON_CTRL_FIE_BIT]; // R6
            rie_r <= CTRL_RST[`SVMON_CTRL_RIE_BIT]; // R7
        end else if (bo_active) begin
            fie_r <= 1'b0;
            rie_r <= 1'b0;
        end else if (wr_ctrl) begin
            fie_r <= reg_wdata[`SVMON_CTRL_FIE_BIT]; // R6
            rie_r <= reg_wdata[`SVMON_CTRL_RIE_BIT]; // R7
        end
    end

    // ======================================================
    // Brownout reset sequencer
    svmon_pkg::svmon_state_t    state_r;
    logic [`SVMON_CNT_W-1:0]    cnt_r;
    localparam logic [`SVMON_CNT_W-1:0] CNT_LAST =
        `SVMON_CNT_W'(`SVMON_RELEASE_CYCLES - 1);

    assign below_lvl = lvl_r ? hi_s : lo_s; // R3

    // Release wait starts over if the supply dips again

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= svmon_pkg::SVMON_RUN;
        end else begin
            unique case (state_r)
                svmon_pkg::SVMON_RUN: begin
                    if (en_r && rst_en_r && below_lvl) begin // R5 R10
                        state_r <= svmon_pkg::SVMON_LOW;
                    end
                end
                svmon_pkg::SVMON_LOW: begin
                    if (!below_lvl) begin
                        state_r <= svmon_pkg::SVMON_WAIT;
                    end
                end
                svmon_pkg::SVMON_WAIT: begin
                    if (below_lvl) begin
                        state_r <= svmon_pkg::SVMON_LOW;
                    end else if (cnt_r == CNT_LAST) begin
                        state_r <= svmon_pkg::SVMON_RUN; // R13
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (state_r == svmon_pkg::SVMON_WAIT && !below_lvl) begin
            cnt_r <= cnt_r + 1'b1; // R13
        end else begin
            cnt_r <= '0;
        end
    end

    assign bo_active = (state_r != svmon_pkg::SVMON_RUN);

    // ======================================================
    // Status flags
    logic fall_flag_r;
    logic rise_flag_r;
    logic fall_d_r;
    logic rise_d_r;
    logic armed_r;
    logic fall_seen_r;
    logic rise_seen_r;
    logic fall_ev;
    logic rise_ev;
    logic rd_stat;

    assign rd_stat = reg_rd && (reg_addr == `SVMON_ADDR_STAT);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fall_d_r <= 1'b0;
            rise_d_r <= 1'b0;
        end else begin
            fall_d_r <= fall_s;
            rise_d_r <= rise_s;
        end
    end

    assign fall_ev = en_r && fall_s && !fall_d_r; // R10

    // Rise counts only after a fall taken while rise enable was 1
    // Pending rise lost once supply sinks below the low reset level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (bo_active || !en_r) begin
            armed_r <= 1'b0;
        end else if (lo_s) begin
            armed_r <= 1'b0; // R12
        end else if (fall_ev) begin
            armed_r <= rie_r; // R12
        end else if (rise_ev) begin
            armed_r <= 1'b0;
        end
    end

    assign rise_ev = en_r && armed_r && rise_s && !rise_d_r; // R12

    // Read-as-1 memory for write-0 clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fall_seen_r <= 1'b0;
            rise_seen_r <= 1'b0;
        end else if (bo_active) begin
            fall_seen_r <= 1'b0;
            rise_seen_r <= 1'b0;
        end else begin
            if (rd_stat && fall_flag_r) begin
                fall_seen_r <= 1'b1; // R11
            end else if (!fall_flag_r) begin
                fall_seen_r <= 1'b0;
            end
            if (rd_stat && rise_flag_r) begin
                rise_seen_r <= 1'b1; // R11
            end else if (!rise_flag_r) begin
                rise_seen_r <= 1'b0;
            end
        end
    end

    // Set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fall_flag_r <= `SVMON_FLAG_RESET;
            rise_flag_r <= `SVMON_FLAG_RESET;
        end else if (bo_active) begin
            fall_flag_r <= `SVMON_FLAG_RESET;
            rise_flag_r <= `SVMON_FLAG_RESET;
        end else begin
            if (fall_ev) begin
                fall_flag_r <= 1'b1; // R11
            end else if (wr_stat && fall_seen_r &&
                         !reg_wdata[`SVMON_STAT_FALL_BIT]) begin
                fall_flag_r <= 1'b0; // R11
            end
            if (rise_ev) begin
                rise_flag_r <= 1'b1; // R11
            end else if (wr_stat && rise_seen_r &&
                         !reg_wdata[`SVMON_STAT_RISE_BIT]) begin
                rise_flag_r <= 1'b0; // R11
            end
        end
    end

    // ======================================================
    // Outputs
    // Requests lag their flags by one cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            monitor_on   <= 1'b0;
            level_sel    <= 1'b0;
            brownout_rst <= 1'b0;
            fall_irq     <= 1'b0;
            rise_irq     <= 1'b0;
        end else begin
            monitor_on   <= en_r;                         // R1
            level_sel    <= lvl_r;                        // R3
            brownout_rst <= bo_active;                    // R5
            fall_irq     <= en_r && fall_flag_r && fie_r; // R15
            rise_irq     <= en_r && rise_flag_r && rie_r; // R15
        end
    end

    // ======================================================
    // Register read
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;

    always_comb begin
        ctrl_view = `SVMON_CTRL_RSVD_MASK; // R2
        ctrl_view[`SVMON_CTRL_EN_BIT]  = en_r;
        ctrl_view[`SVMON_CTRL_LVL_BIT] = lvl_r;
        ctrl_view[`SVMON_CTRL_RST_BIT] = rst_en_r;
        ctrl_view[`SVMON_CTRL_FIE_BIT] = fie_r;
        ctrl_view[`SVMON_CTRL_RIE_BIT] = rie_r;
        stat_view = `SVMON_STAT_RSVD_MASK;
        stat_view[`SVMON_STAT_FALL_BIT] = fall_flag_r;
        stat_view[`SVMON_STAT_RISE_BIT] = rise_flag_r;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SVMON_ADDR_CTRL:     reg_rdata <= ctrl_view;
                `SVMON_ADDR_STAT:     reg_rdata <= stat_view;
                `SVMON_ADDR_STAT_RAW: reg_rdata <= {4'h0, cmp_s2_r};
                default:              reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ### svmon_ctrl_properties.sv
// Assertions on the ports of the supply monitor control block
`timescale 1ns/1ps
`include "svmon_params.svh"
module svmon_props (
    input wire logic       clk_sys,      // Clock
    input wire logic       rst_n,        // Reset
    input wire logic [3:0] reg_addr,     // Address
    input wire logic [7:0] reg_wdata,    // Write data
    input wire logic       reg_wr,       // Write strobe
    input wire logic       reg_rd,       // Read strobe
    input wire logic [7:0] reg_rdata,    // Read data
    input wire logic       cmp_fall,     // Fall comparator
    input wire logic       cmp_rise,     // Rise comparator
    input wire logic       cmp_reset_lo, // Low level comparator
    input wire logic       cmp_reset_hi, // High level comparator
    input wire logic       monitor_on,   // Unit active
    input wire logic       level_sel,    // Reset level
    input wire logic       brownout_rst, // Internal reset
    input wire logic       fall_irq,     // Fall request
    input wire logic       rise_irq      // Rise request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire ctrl_wr = reg_wr && reg_addr == `SVMON_ADDR_CTRL;
    wire ctrl_rd = reg_rd && reg_addr == `SVMON_ADDR_CTRL;
    a_rsvd_read_ones: assert property (ctrl_rd |=>
        reg_rdata[6:4] == 3'h7)
        else $error("reserved control bits not read as ones");
    a_enable_follows: assert property (ctrl_wr |=> ##1
        monitor_on == $past(reg_wdata[7], 2))
        else $error("monitor_on does not follow write");
    a_level_follows: assert property (ctrl_wr |=> ##1
        level_sel == $past(reg_wdata[3], 2))
        else $error("level_sel does not follow write");
    a_fall_masked: assert property (ctrl_wr && !reg_wdata[1] |=>
        ##1 !fall_irq)
        else $error("fall request while disabled");
    a_rise_masked: assert property (ctrl_wr && !reg_wdata[0] |=>
        ##1 !rise_irq)
        else $error("rise request while disabled");
    a_off_no_irq: assert property (!monitor_on |->
        !fall_irq && !rise_irq)
        else $error("request while unit off");
    a_bo_needs_on: assert property ($rose(brownout_rst) |->
        $past(monitor_on))
        else $error("brownout while unit off");
    a_bo_held_low: assert property (brownout_rst &&
        $past(cmp_reset_lo, 3) && $past(cmp_reset_hi, 3) |=> brownout_rst)
        else $error("brownout released while supply low");
    a_kept_in_bo: assert property (brownout_rst && !$past(reg_wr) |=>
        $stable(monitor_on) && $stable(level_sel))
        else $error("kept bits changed in brownout");
    cover property (fall_irq);
    cover property (rise_irq);
    cover property ($rose(brownout_rst));
endmodule
bind svmon_ctrl svmon_props u_props (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cmp_fall, .cmp_rise, .cmp_reset_lo,
    .cmp_reset_hi, .monitor_on, .level_sel, .brownout_rst, .fall_irq,
    .rise_irq);

// ### testbench.sv
// Self-checking testbench for the supply monitor control block
`timescale 1ns/1ps
`include "svmon_params.svh"
module testbench;
    logic       clk_sys, rst_n, reg_wr, reg_rd, monitor_on, level_sel;
    logic       cmp_fall, cmp_rise, cmp_reset_lo, cmp_reset_hi;
    logic       brownout_rst, fall_irq, rise_irq;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [7:0] combo [7] = '{8'h00, 8'h0f, 8'h88, 8'h8c, 8'h82, 8'h83,
                              8'h87};
    int         num_errors = 0;
    int         total_checks = 0;
    int         cyc = 0;
    svmon_ctrl dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cmp_fall, .cmp_rise, .cmp_reset_lo, .cmp_reset_hi,
        .monitor_on, .level_sel, .brownout_rst, .fall_irq, .rise_irq);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3 * `SVMON_EN_SETTLE_CYCLES + 5000) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end
    task automatic cmp8(input string what, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp1(input string what, input logic e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 cmp8("reg_rdata", e, reg_rdata);
    endtask
    // Comparators {fall, rise, lo, hi}, then let the synchronisers settle
    task automatic setc(input logic [3:0] v);
        @(posedge clk_sys);
        {cmp_fall, cmp_rise, cmp_reset_lo, cmp_reset_hi} <= v;
        repeat (6) @(posedge clk_sys);
    endtask
    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {cmp_fall, cmp_rise, cmp_reset_lo, cmp_reset_hi} = 4'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`SVMON_ADDR_CTRL, 8'h70);
        rd(`SVMON_ADDR_STAT, 8'hfc);
        rd(4'hf, 8'h00);
        foreach (combo[i]) begin
            wr(`SVMON_ADDR_CTRL, combo[i]);
            rd(`SVMON_ADDR_CTRL, combo[i] | 8'h70);
            cmp1("monitor_on", combo[i][7], monitor_on);
            cmp1("level_sel", combo[i][3], level_sel);
            if (combo[i] == 8'h88)
                repeat (`SVMON_EN_SETTLE_CYCLES) @(posedge clk_sys);
        end
        $display("Test registers done");
        wr(`SVMON_ADDR_CTRL, 8'h83);
        setc(4'h8);
        rd(`SVMON_ADDR_STAT_RAW, 8'h08);
        wr(`SVMON_ADDR_STAT, 8'hfc);
        rd(`SVMON_ADDR_STAT, 8'hfe);
        cmp1("fall_irq", 1'b1, fall_irq);
        cmp1("rise_irq", 1'b0, rise_irq);
        setc(4'h4);
        rd(`SVMON_ADDR_STAT, 8'hff);
        cmp1("rise_irq", 1'b1, rise_irq);
        wr(`SVMON_ADDR_STAT, 8'hfc);
        rd(`SVMON_ADDR_STAT, 8'hfc);
        cmp1("fall_irq", 1'b0, fall_irq);
        wr(`SVMON_ADDR_CTRL, 8'h82);
        setc(4'h8);
        setc(4'h4);
        rd(`SVMON_ADDR_STAT, 8'hfe);
        wr(`SVMON_ADDR_STAT, 8'hfc);
        wr(`SVMON_ADDR_CTRL, 8'h03);
        setc(4'h8);
        setc(4'h4);
        rd(`SVMON_ADDR_STAT, 8'hfc);
        cmp1("fall_irq", 1'b0, fall_irq);
        $display("Test flags done");
        wr(`SVMON_ADDR_CTRL, 8'h83);
        repeat (`SVMON_EN_SETTLE_CYCLES) @(posedge clk_sys);
        setc(4'h3);
        cmp1("brownout_rst", 1'b0, brownout_rst);
        setc(4'h1);
        wr(`SVMON_ADDR_CTRL, 8'h87);
        setc(4'h1);
        cmp1("brownout_rst", 1'b0, brownout_rst);
        setc(4'h3);
        cmp1("brownout_rst", 1'b1, brownout_rst);
        rd(`SVMON_ADDR_CTRL, 8'hf4);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`SVMON_ADDR_CTRL, 8'h70);
        cmp1("brownout_rst", 1'b0, brownout_rst);
        wr(`SVMON_ADDR_CTRL, 8'h88);
        repeat (`SVMON_EN_SETTLE_CYCLES) @(posedge clk_sys);
        setc(4'h1);
        wr(`SVMON_ADDR_CTRL, 8'h8c);
        setc(4'h1);
        cmp1("brownout_rst", 1'b1, brownout_rst);
        $display("Test brownout done");
        report_and_stop();
    end
endmodule
